/* shift_move_indirect_exec.sv */
/*
 * execution of right shift, file move, indirect load and bank literal
 * load. assumes the core presents one decoded instruction per cycle,
 * reads the file operand for it and accepts a file write-back strobe;
 * indirect data is read combinationally from data memory.
 */
`timescale 1ns/1ps
module shift_move_indirect_exec
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic instr_valid,
    input wire shift_move_pkg::exec_op_e instr_op,
    input wire logic dest_sel,
    input wire logic [shift_move_pkg::DATA_W-1:0] file_data,
    input wire logic pointer_sel,
    input wire logic [1:0] pointer_update_mode,
    input wire logic relative_form,
    input wire logic [shift_move_pkg::OFS_W-1:0] rel_offset,
    input wire logic [shift_move_pkg::BANK_W-1:0] bank_literal,
    input wire logic [shift_move_pkg::DATA_W-1:0] mem_rdata,
    output logic [shift_move_pkg::PTR_W-1:0] mem_addr,
    output logic [shift_move_pkg::DATA_W-1:0] file_wdata,
    output logic file_we,
    output logic [shift_move_pkg::DATA_W-1:0] acc,
    output logic zero_flag,
    output logic carry_flag,
    output logic [shift_move_pkg::BANK_W-1:0] bank_select_register,
    output logic [shift_move_pkg::PTR_W-1:0] file_select_pointer0,
    output logic [shift_move_pkg::PTR_W-1:0] file_select_pointer1
);
    import shift_move_pkg::*;

    // ==========================================================
    // state
    logic [DATA_W-1:0] acc_q, acc_d;
    logic zero_q, zero_d;
    logic carry_q, carry_d;
    logic [BANK_W-1:0] bank_q, bank_d;
    logic [PTR_W-1:0] ptr_q [2];
    logic [PTR_W-1:0] ptr_d [2];
    logic [DATA_W-1:0] fwd_q, fwd_d;
    logic fwe_q, fwe_d;
    logic [PTR_W-1:0] cur_ptr;
    logic [PTR_W-1:0] eff_addr;
    logic [PTR_W-1:0] ptr_next;
    logic [DATA_W-1:0] result;

    function automatic logic is_zero(input logic [DATA_W-1:0] v);
        return v == '0;
    endfunction

    // ==========================================================
    // pointer arithmetic
    assign cur_ptr = ptr_q[pointer_sel];

    pointer_step #(.PW(PTR_W)) u_step
    (
        .ptr(cur_ptr),
        .pointer_update_mode(pointer_update_mode),
        .relative_form(relative_form),
        .offset(rel_offset),
        .eff_addr(eff_addr),
        .ptr_next(ptr_next)
    );

    // indirect location has no storage; address goes straight to memory
    assign mem_addr = eff_addr;

    // ==========================================================
    // next-state computation
    always_comb
    begin
        acc_d = acc_q;
        zero_d = zero_q;
        carry_d = carry_q;
        bank_d = bank_q;
        ptr_d = ptr_q;
        fwd_d = fwd_q;
        fwe_d = 1'b0;
        result = '0;
        if (instr_valid)
        begin
            unique case (instr_op)
                logical_right_shift_op:
                begin
                    result = {1'b0, file_data[7:1]};
                    carry_d = file_data[0];
                    zero_d = is_zero(result);
                    if (dest_sel)
                    begin
                        fwd_d = result;
                        fwe_d = 1'b1;
                    end
                    else
                    begin
                        acc_d = result;
                    end
                end
                file_move_op:
                begin
                    result = file_data;
                    zero_d = is_zero(result);
                    if (dest_sel)
                    begin
                        fwd_d = result;
                        fwe_d = 1'b1;
                    end
                    else
                    begin
                        acc_d = result;
                    end
                end
                indirect_load_op:
                begin
                    acc_d = mem_rdata;
                    zero_d = is_zero(mem_rdata);
                    // carry deliberately untouched by stepping
                    ptr_d[pointer_sel] = ptr_next;
                end
                bank_literal_load_op:
                begin
                    bank_d = bank_literal;
                end
                default:
                begin
                end
            endcase
        end
    end

    // registers
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            acc_q <= ACC_RESET;
            zero_q <= 1'b0;
            carry_q <= 1'b0;
            bank_q <= BANK_RESET;
            ptr_q[0] <= PTR_RESET;
            ptr_q[1] <= PTR_RESET;
            fwd_q <= ACC_RESET;
            fwe_q <= 1'b0;
        end
        else
        begin
            acc_q <= acc_d;
            zero_q <= zero_d;
            carry_q <= carry_d;
            bank_q <= bank_d;
            ptr_q <= ptr_d;
            fwd_q <= fwd_d;
            fwe_q <= fwe_d;
        end
    end

    // ==========================================================
    // outputs, all registered except mem_addr
    assign acc = acc_q;
    assign zero_flag = zero_q;
    assign carry_flag = carry_q;
    assign bank_select_register = bank_q;
    assign file_select_pointer0 = ptr_q[0];
    assign file_select_pointer1 = ptr_q[1];
    assign file_wdata = fwd_q;
    assign file_we = fwe_q;

    // ==========================================================
    // checks
    a_shift_result: assert property (@(posedge ref_clk) disable iff (reset)
        instr_valid && instr_op == logical_right_shift_op
        |=> carry_flag == $past(file_data[0]) && (file_we ? file_wdata : acc) == ($past(file_data) >> 1))
        else $error("right shift result wrong");
    a_shift_dest: assert property (@(posedge ref_clk) disable iff (reset)
        instr_valid && instr_op == logical_right_shift_op |=> file_we == $past(dest_sel))
        else $error("shift destination wrong");
    a_shift_zero: assert property (@(posedge ref_clk) disable iff (reset)
        instr_valid && instr_op == logical_right_shift_op |=> zero_flag == ($past(file_data[7:1]) == 7'h00))
        else $error("shift zero flag wrong");
    a_move_dest: assert property (@(posedge ref_clk) disable iff (reset)
        instr_valid && instr_op == file_move_op && !dest_sel |=> acc == $past(file_data) && !file_we)
        else $error("move to accumulator wrong");
    a_move_zero: assert property (@(posedge ref_clk) disable iff (reset)
        instr_valid && instr_op == file_move_op |=> zero_flag == ($past(file_data) == 8'h00))
        else $error("move zero flag wrong");
    a_preinc_addr: assert property (@(posedge ref_clk) disable iff (reset)
        instr_valid && instr_op == indirect_load_op && !relative_form && pointer_update_mode == MODE_PRE_INC
        |-> mem_addr == cur_ptr + 16'h0001)
        else $error("preincrement address wrong");
    a_rel_keep: assert property (@(posedge ref_clk) disable iff (reset)
        instr_valid && instr_op == indirect_load_op && relative_form
        |-> mem_addr == cur_ptr + {{10{rel_offset[5]}}, rel_offset} ##1 $stable(file_select_pointer0)
        && $stable(file_select_pointer1))
        else $error("relative form wrong");
    a_post_dec: assert property (@(posedge ref_clk) disable iff (reset)
        instr_valid && instr_op == indirect_load_op && !relative_form && pointer_update_mode == MODE_POST_DEC
        && !pointer_sel |-> mem_addr == file_select_pointer0 ##1 file_select_pointer0 == $past(mem_addr) - 16'h0001)
        else $error("postdecrement wrong");
    a_load_acc: assert property (@(posedge ref_clk) disable iff (reset)
        instr_valid && instr_op == indirect_load_op |=> acc == $past(mem_rdata)
        && zero_flag == ($past(mem_rdata) == 8'h00))
        else $error("indirect load wrong");
    a_bank_flags: assert property (@(posedge ref_clk) disable iff (reset)
        instr_valid && instr_op == bank_literal_load_op
        |=> bank_select_register == $past(bank_literal) && $stable(zero_flag) && $stable(carry_flag))
        else $error("bank load wrong");
    a_step_carry: assert property (@(posedge ref_clk) disable iff (reset)
        instr_valid && instr_op == indirect_load_op |=> $stable(carry_flag))
        else $error("pointer step touched carry");
    c_shift_wb: cover property (@(posedge ref_clk) instr_valid && instr_op == logical_right_shift_op && dest_sel);
    c_self_move: cover property (@(posedge ref_clk) instr_valid && instr_op == file_move_op && dest_sel);
    c_wrap: cover property (@(posedge ref_clk) instr_valid && instr_op == indirect_load_op
        && cur_ptr == 16'hffff && !relative_form
        && (pointer_update_mode == MODE_PRE_INC || pointer_update_mode == MODE_POST_INC));
    c_bank: cover property (@(posedge ref_clk) instr_valid && instr_op == bank_literal_load_op);
endmodule

/* shift_move_pkg.sv */
/*
 * constants for the shift / move / indirect-load execution block.
 * assumes a single core clock; instructions arrive already decoded.
 */
package shift_move_pkg;
    // ==========================================================
    // operation codes
    typedef enum logic [2:0] {
        op_none,
        logical_right_shift_op,
        file_move_op,
        indirect_load_op,
        bank_literal_load_op
    } exec_op_e;

    // ==========================================================
    // widths and field values
    localparam int DATA_W = 8;
    localparam int PTR_W = 16;
    localparam int BANK_W = 5;
    localparam int OFS_W = 6;
    localparam logic [1:0] MODE_PRE_INC = 2'h0;
    localparam logic [1:0] MODE_PRE_DEC = 2'h1;
    localparam logic [1:0] MODE_POST_INC = 2'h2;
    localparam logic [1:0] MODE_POST_DEC = 2'h3;
    localparam logic [15:0] PTR_RESET = 16'h0000;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [4:0] BANK_RESET = 5'h00;
endpackage

/* pointer_step.sv */
/*
 * pointer arithmetic for the indirect load: effective address and
 * pointer write-back value. purely combinational.
 * assumes the caller holds the pointer and registers the write-back value, not the address.
 */
`timescale 1ns/1ps
module pointer_step
    import shift_move_pkg::*;
#(
    parameter int PW = PTR_W
)
(
    input wire logic [PW-1:0] ptr,
    input wire logic [1:0] pointer_update_mode,
    input wire logic relative_form,
    input wire logic [OFS_W-1:0] offset,
    output logic [PW-1:0] eff_addr,
    output logic [PW-1:0] ptr_next
);
    import shift_move_pkg::*;

    // elaboration-time guard: the signed offset must fit inside the pointer
    if (PW < OFS_W)
    begin : g_bad_width
        $error("pointer narrower than offset");
    end

    logic [PW-1:0] plus_one;
    logic [PW-1:0] minus_one;
    logic [PW-1:0] ofs_ext;

    // ==========================================================
    // arithmetic wraps naturally modulo the pointer range
    assign plus_one = ptr + PW'(1);
    assign minus_one = ptr - PW'(1);
    assign ofs_ext = PW'(signed'(offset));

    // address and write-back select
    always_comb
    begin
        eff_addr = ptr;
        ptr_next = ptr;
        if (relative_form)
        begin
            eff_addr = ptr + ofs_ext;
        end
        else
        begin
            unique case (pointer_update_mode)
                MODE_PRE_INC:
                begin
                    eff_addr = plus_one;
                    ptr_next = plus_one;
                end
                MODE_PRE_DEC:
                begin
                    eff_addr = minus_one;
                    ptr_next = minus_one;
                end
                MODE_POST_INC:
                begin
                    ptr_next = plus_one;
                end
                MODE_POST_DEC:
                begin
                    ptr_next = minus_one;
                end
            endcase
        end
    end
endmodule

/* testbench.sv */
/*
 * self-checking bench for the shift / move / indirect-load block.
 * assumes the block's own assertions sit in its files; data memory is
 * modelled here as a combinational function of the address.
 */
`timescale 1ns/1ps
module testbench;
    import shift_move_pkg::*;
    // ==========================================================
    // clock, stimulus and observed signals
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic instr_valid = 1'b0;
    exec_op_e instr_op = op_none;
    logic dest_sel = 1'b0;
    logic [7:0] file_data = 8'h00;
    logic pointer_sel = 1'b0;
    logic [1:0] pointer_update_mode = 2'h0;
    logic relative_form = 1'b0;
    logic [5:0] rel_offset = 6'h00;
    logic [4:0] bank_literal = 5'h00;
    logic [7:0] mem_rdata;
    logic [15:0] mem_addr, fsp0, fsp1, ptr_m[2];
    logic [7:0] file_wdata, acc;
    logic file_we, zero_flag, carry_flag;
    logic [4:0] bank_select_register;
    int errors = 0;
    int samples_checked = 0;
    int cycles = 0;

    always #2 ref_clk = ~ref_clk;

    // address-dependent contents, so a wrong address reads wrong data
    function automatic logic [7:0] mem_of(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h01;
    endfunction
    assign mem_rdata = mem_of(mem_addr);

    shift_move_indirect_exec i_dut (.ref_clk(ref_clk), .reset(reset), .instr_valid(instr_valid),
        .instr_op(instr_op), .dest_sel(dest_sel), .file_data(file_data), .pointer_sel(pointer_sel),
        .pointer_update_mode(pointer_update_mode), .relative_form(relative_form), .rel_offset(rel_offset),
        .bank_literal(bank_literal), .mem_rdata(mem_rdata), .mem_addr(mem_addr), .file_wdata(file_wdata),
        .file_we(file_we), .acc(acc), .zero_flag(zero_flag), .carry_flag(carry_flag),
        .bank_select_register(bank_select_register), .file_select_pointer0(fsp0),
        .file_select_pointer1(fsp1));

    // ==========================================================
    // shared helpers
    // wide enough for the widest packed compare (45 bits at reset)
    task automatic check(input logic [47:0] got, input logic [47:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one instruction: an idle cycle first, so valid never drops and rises in one step
    task automatic go(input exec_op_e op);
        @(negedge ref_clk);
        instr_op = op;
        instr_valid = 1'b1;
        @(negedge ref_clk);
        instr_valid = 1'b0;
    endtask

    task automatic final_report();
        $display("checks=%0d mismatches=%0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ==========================================================
    // scenarios
    task automatic t_shift();
        dest_sel = 1'b1;
        file_data = 8'h81;
        go(logical_right_shift_op);
        check(file_we, 1'b1);
        check(file_wdata, 8'h40);
        check({carry_flag, zero_flag}, 2'b10);
        dest_sel = 1'b0;
        file_data = 8'h01;
        go(logical_right_shift_op);
        check({file_we, acc}, 9'h000);
        check({carry_flag, zero_flag}, 2'b11);
        $display("shift test done");
    endtask

    task automatic t_move();
        dest_sel = 1'b0;
        file_data = 8'ha5;
        go(file_move_op);
        check({file_we, acc, zero_flag}, {1'b0, 8'ha5, 1'b0});
        dest_sel = 1'b1;
        file_data = 8'h00;
        go(file_move_op);
        check({file_we, file_wdata, acc}, {1'b1, 8'h00, 8'ha5});
        check(zero_flag, 1'b1);
        $display("move test done");
    endtask

    // indirect load with expectation worked out from the pointer model
    task automatic ind(input logic s, input logic [1:0] m, input logic r, input logic [5:0] o);
        logic [15:0] p, ea, pn;
        logic c;
        @(negedge ref_clk);
        p = ptr_m[s];
        ea = r ? p + {{10{o[5]}}, o} : (m == 2'h0 ? p + 16'h1 : (m == 2'h1 ? p - 16'h1 : p));
        pn = r ? p : (m[0] ? p - 16'h1 : p + 16'h1);
        c = carry_flag;
        pointer_sel = s;
        pointer_update_mode = m;
        relative_form = r;
        rel_offset = o;
        instr_op = indirect_load_op;
        instr_valid = 1'b1;
        #1 check(mem_addr, ea);
        @(negedge ref_clk);
        instr_valid = 1'b0;
        check(acc, mem_of(ea));
        check(zero_flag, mem_of(ea) == 8'h00);
        check(carry_flag, c);
        check(s ? fsp1 : fsp0, pn);
        check(s ? fsp0 : fsp1, ptr_m[!s]);
        ptr_m[s] = pn;
    endtask

    task automatic t_indirect();
        ptr_m[0] = 16'h0000;
        ptr_m[1] = 16'h0000;
        for (int m = 0; m < 4; m++)
            ind(1'b0, m[1:0], 1'b0, 6'h00);
        ind(1'b1, MODE_POST_DEC, 1'b0, 6'h00);
        ind(1'b1, MODE_PRE_INC, 1'b0, 6'h00);
        ind(1'b1, MODE_PRE_DEC, 1'b1, 6'h20);
        ind(1'b1, MODE_POST_INC, 1'b1, 6'h1f);
        $display("indirect test done");
    endtask

    task automatic t_bank();
        logic [1:0] f;
        f = {carry_flag, zero_flag};
        bank_literal = 5'h1f;
        go(bank_literal_load_op);
        check(bank_select_register, 5'h1f);
        check({carry_flag, zero_flag}, f);
        bank_literal = 5'h0a;
        go(op_none);
        check(bank_select_register, 5'h1f);
        go(bank_literal_load_op);
        check(bank_select_register, 5'h0a);
        $display("bank test done");
    endtask

    // ==========================================================
    // timeout and main sequence
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            errors++;
            final_report();
        end
    end

    initial
    begin
        repeat (8) @(negedge ref_clk);
        reset = 1'b0;
        check({acc, bank_select_register, fsp0, fsp1}, 45'h0);
        t_shift();
        t_move();
        t_indirect();
        t_bank();
        final_report();
    end
endmodule
